/* scs_speed_cmd.sv */
// Speed-mode command conditioning and speed status flags
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
module scs_speed_cmd
	import scs_pkg::*;
(
	input  wire logic                     CLK_SYS_IN,
	input  wire logic                     NRST_IN,
	input  wire logic [ADDR_W-1:0]        ADDR_IN,
	input  wire logic [DATA_W-1:0]        WDATA_IN,
	input  wire logic                     WR_IN,
	input  wire logic                     RD_IN,
	output logic [DATA_W-1:0]             RDATA_OUT,
	input  wire scs_pkg::scs_din_t        DIN_IN,
	input  wire logic signed [SPD_W-1:0]  SPEED_CMD_IN,
	input  wire logic signed [SPD_W-1:0]  SPEED_FB_IN,
	input  wire logic signed [POS_W-1:0]  POS_FB_IN,
	output logic signed [SPD_W-1:0]       SPEED_OUT,
	output logic                          ZERO_LOCK_OUT,
	output scs_pkg::scs_status_t          STATUS_OUT
);
	import scs_pkg::*;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	scs_din_t din_m_q;
	scs_din_t din_q;

	// Digital inputs come from pins: two flops before use
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			din_m_q <= '0;
			din_q   <= '0;
		end
		else
		begin
			din_m_q <= DIN_IN;
			din_q   <= din_m_q;
		end
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [SPD_W-1:0]        zero_lock_speed_threshold_q;
	logic [SPD_W-1:0]        jog_speed_setting_q;
	logic [SPD_W-1:0]        speed_consistency_threshold_q;
	logic [SPD_W-1:0]        speed_reaching_threshold_q;
	logic [SPD_W-1:0]        zero_speed_threshold_q;
	logic [SPD_W-1:0]        accel_decel_threshold_q;
	logic [FILT_SHIFT_W-1:0] feedback_filter_time_q;
	logic [FILT_SHIFT_W-1:0] display_filter_time_q;
	logic                    speed_mode_q;

	// Software writes; one cycle, no wait
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			zero_lock_speed_threshold_q   <= RST_ZLOCK_THR;
			jog_speed_setting_q           <= RST_JOG_SPEED;
			speed_consistency_threshold_q <= RST_CONS_THR;
			speed_reaching_threshold_q    <= RST_REACH_THR;
			zero_speed_threshold_q        <= RST_ZERO_THR;
			accel_decel_threshold_q       <= RST_ACC_THR;
			feedback_filter_time_q        <= RST_FB_FILT;
			display_filter_time_q         <= RST_DISP_FILT;
			speed_mode_q                  <= 1'b1;
		end
		else if (WR_IN)
		begin
			unique case (ADDR_IN)
				ADR_ZLOCK_THR: zero_lock_speed_threshold_q   <= WDATA_IN;
				ADR_JOG_SPEED: jog_speed_setting_q           <= WDATA_IN;
				ADR_CONS_THR:  speed_consistency_threshold_q <= WDATA_IN;
				ADR_REACH_THR: speed_reaching_threshold_q    <= WDATA_IN;
				ADR_ZERO_THR:  zero_speed_threshold_q        <= WDATA_IN;
				ADR_ACC_THR:   accel_decel_threshold_q       <= WDATA_IN;
				ADR_FB_FILT:
					feedback_filter_time_q <= WDATA_IN[FILT_SHIFT_W-1:0];
				ADR_DISP_FILT:
					display_filter_time_q <= WDATA_IN[FILT_SHIFT_W-1:0];
				ADR_CTRL:      speed_mode_q <= WDATA_IN[CTRL_SPEED_MODE];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Speed feedback filters
	// ****************************************************************
	logic signed [SPD_W-1:0] filtered_actual_speed;
	logic signed [SPD_W-1:0] display_speed;

	// Control filter drives all status decisions
	scs_lpf #(.W(SPD_W)) u_fb_filt (
		.clk_in   (CLK_SYS_IN),
		.nrst_in  (NRST_IN),
		.x_in     (SPEED_FB_IN),
		.shift_in (feedback_filter_time_q),
		.y_out    (filtered_actual_speed)
	);

	// Display copy has its own constant, so a slow display never delays control
	scs_lpf #(.W(SPD_W)) u_disp_filt (
		.clk_in   (CLK_SYS_IN),
		.nrst_in  (NRST_IN),
		.x_in     (SPEED_FB_IN),
		.shift_in (display_filter_time_q),
		.y_out    (display_speed)
	);

	// ****************************************************************
	// Command conditioning
	// ****************************************************************
	logic signed [SPD_W+1:0] cmd_wide;
	logic signed [SPD_W-1:0] cmd_mod;
	logic signed [SPD_W-1:0] cmd_final;

	// Invert, then jog, saturate, then pause last
	always_comb
	begin
		cmd_wide = (SPD_W+2)'(SPEED_CMD_IN);
		if (din_q.cmd_invert_in)
			cmd_wide = -cmd_wide;
		if (speed_mode_q && din_q.fwd_jog_in)
			cmd_wide = cmd_wide + (SPD_W+2)'(jog_speed_setting_q);
		if (speed_mode_q && din_q.rev_jog_in)
			cmd_wide = cmd_wide - (SPD_W+2)'(jog_speed_setting_q);
		if (cmd_wide > 18'sd32767)
			cmd_mod = 16'sh7FFF;
		else if (cmd_wide < -18'sd32767)
			cmd_mod = -16'sh7FFF;
		else
			cmd_mod = cmd_wide[SPD_W-1:0];
		cmd_final = din_q.speed_pause_in ? '0 : cmd_mod;
	end

	// ****************************************************************
	// Zero-position lock
	// ****************************************************************
	scs_lock_t         lock_q;
	logic              lock_cond;
	logic signed [POS_W-1:0] lock_pos_q;
	logic signed [POS_W-1:0] pos_err;
	logic signed [SPD_W-1:0] hold_cmd;

	assign lock_cond = speed_mode_q && din_q.zero_lock_enable_in &&
		(scs_abs(cmd_final) <= zero_lock_speed_threshold_q);

	// Lock entry and exit
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
			lock_q <= ST_FOLLOW;
		else
		begin
			unique case (lock_q)
				ST_FOLLOW:
					if (lock_cond)
						lock_q <= ST_ZLOCK;
				ST_ZLOCK:
					if (!lock_cond)
						lock_q <= ST_FOLLOW;
			endcase
		end
	end

	// Position captured on the entry edge
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
			lock_pos_q <= '0;
		else if (lock_q == ST_FOLLOW && lock_cond)
			lock_pos_q <= POS_FB_IN;
	end

	// Proportional hold; deadband of one pulse keeps it from hunting
	always_comb
	begin
		pos_err = lock_pos_q - POS_FB_IN;
		if (pos_err > 32'sd1 || pos_err < -32'sd1)
		begin
			if (pos_err > 32'sd32767)
				hold_cmd = 16'sh7FFF;
			else if (pos_err < -32'sd32767)
				hold_cmd = -16'sh7FFF;
			else
				hold_cmd = pos_err[SPD_W-1:0];
		end
		else
			hold_cmd = '0;
	end

	// Output command register
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
			SPEED_OUT <= RST_ZERO_SPD;
		else if (lock_q == ST_ZLOCK)
			SPEED_OUT <= hold_cmd;
		else
			SPEED_OUT <= cmd_final;
	end

	assign ZERO_LOCK_OUT = (lock_q == ST_ZLOCK);

	// ****************************************************************
	// Status flags
	// ****************************************************************
	logic signed [SPD_W-1:0] prev_speed_q;
	logic signed [SPD_W:0]   accel;
	logic [SPD_W:0]          acc_mag;
	logic signed [SPD_W:0]   cons_diff;
	logic [SPD_W:0]          cons_mag;
	logic [SPD_W-1:0]        spd_mag;

	always_comb
	begin
		accel     = (SPD_W+1)'(filtered_actual_speed) -
			(SPD_W+1)'(prev_speed_q);
		acc_mag   = (accel < 0) ? (SPD_W+1)'(-accel) : accel;
		cons_diff = (SPD_W+1)'(filtered_actual_speed) -
			(SPD_W+1)'(cmd_final);
		cons_mag  = (cons_diff < 0) ? (SPD_W+1)'(-cons_diff) : cons_diff;
		spd_mag   = scs_abs(filtered_actual_speed);
	end

	// Speed sample for the per-cycle derivative
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
			prev_speed_q <= '0;
		else
			prev_speed_q <= filtered_actual_speed;
	end

	// Flags registered; acceleration means magnitude rising
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
			STATUS_OUT <= '0;
		else
		begin
			STATUS_OUT.speed_consistent_out <=
				cons_mag < (SPD_W+1)'(speed_consistency_threshold_q);
			STATUS_OUT.speed_reached_out <=
				spd_mag > speed_reaching_threshold_q;
			STATUS_OUT.zero_speed_out <=
				spd_mag < zero_speed_threshold_q;
			STATUS_OUT.accelerating_out <=
				(spd_mag > scs_abs(prev_speed_q)) &&
				(acc_mag > (SPD_W+1)'(accel_decel_threshold_q));
			STATUS_OUT.decelerating_out <=
				(spd_mag < scs_abs(prev_speed_q)) &&
				(acc_mag > (SPD_W+1)'(accel_decel_threshold_q));
			STATUS_OUT.fwd_rotation_out <= filtered_actual_speed >
				signed'({1'b0, zero_speed_threshold_q[SPD_W-2:0]});
			STATUS_OUT.rev_rotation_out <= filtered_actual_speed <
				-signed'({1'b0, zero_speed_threshold_q[SPD_W-2:0]});
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
			RDATA_OUT <= '0;
		else if (RD_IN)
		begin
			unique case (ADDR_IN)
				ADR_ZLOCK_THR:  RDATA_OUT <= zero_lock_speed_threshold_q;
				ADR_JOG_SPEED:  RDATA_OUT <= jog_speed_setting_q;
				ADR_CONS_THR:   RDATA_OUT <= speed_consistency_threshold_q;
				ADR_REACH_THR:  RDATA_OUT <= speed_reaching_threshold_q;
				ADR_ZERO_THR:   RDATA_OUT <= zero_speed_threshold_q;
				ADR_ACC_THR:    RDATA_OUT <= accel_decel_threshold_q;
				ADR_FB_FILT:
					RDATA_OUT <= DATA_W'(feedback_filter_time_q);
				ADR_DISP_FILT:
					RDATA_OUT <= DATA_W'(display_filter_time_q);
				ADR_FILT_SPEED: RDATA_OUT <= filtered_actual_speed;
				ADR_DISP_SPEED: RDATA_OUT <= display_speed;
				ADR_SPEED_OUT:  RDATA_OUT <= SPEED_OUT;
				ADR_STATUS:
					RDATA_OUT <= DATA_W'({ZERO_LOCK_OUT, STATUS_OUT});
				ADR_CTRL:       RDATA_OUT <= DATA_W'(speed_mode_q);
				default:        RDATA_OUT <= '0;
			endcase
		end
		else
			RDATA_OUT <= '0;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!NRST_IN);

	a_pause_zeroes: assert property (
		din_q.speed_pause_in && lock_q == ST_FOLLOW |=> SPEED_OUT == 0)
		else $error("pause did not zero the command");
	a_lock_needs_en: assert property (
		!din_q.zero_lock_enable_in |=> lock_q == ST_FOLLOW)
		else $error("lock entered without enable");
	a_lock_entry: assert property (
		lock_cond |=> lock_q == ST_ZLOCK)
		else $error("lock not entered");
	a_lock_exit: assert property (
		lock_q == ST_ZLOCK && !lock_cond |=> lock_q == ST_FOLLOW)
		else $error("lock not left");
	a_lock_hold: assert property (
		lock_q == ST_ZLOCK && $stable(POS_FB_IN) &&
		POS_FB_IN == lock_pos_q |=> SPEED_OUT == 0)
		else $error("lock moved at locked position");
	a_reach_flag: assert property (
		spd_mag > speed_reaching_threshold_q |=>
		STATUS_OUT.speed_reached_out)
		else $error("reached flag missing");
	a_zero_flag: assert property (
		spd_mag < zero_speed_threshold_q |=> STATUS_OUT.zero_speed_out)
		else $error("zero speed flag missing");
	a_dir_excl: assert property (
		!(STATUS_OUT.fwd_rotation_out && STATUS_OUT.rev_rotation_out))
		else $error("both directions flagged");
	a_acc_excl: assert property (
		!(STATUS_OUT.accelerating_out && STATUS_OUT.decelerating_out))
		else $error("accel and decel together");
	a_read_once: assert property (
		!RD_IN |=> RDATA_OUT == 0)
		else $error("read data outside read cycle");

	c_lock: cover property (lock_q == ST_FOLLOW ##1 lock_q == ST_ZLOCK);
	c_jog: cover property (din_q.fwd_jog_in && !din_q.speed_pause_in);
	c_accel: cover property (STATUS_OUT.accelerating_out);
	c_reached: cover property (STATUS_OUT.speed_reached_out);

endmodule : scs_speed_cmd

/* scs_pkg.sv */
// Package with register map, field layout and constants for speed command block
package scs_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int SPD_W  = 16;
	localparam int POS_W  = 32;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ADR_ZLOCK_THR   = 8'h00;
	localparam logic [ADDR_W-1:0] ADR_JOG_SPEED   = 8'h01;
	localparam logic [ADDR_W-1:0] ADR_CONS_THR    = 8'h02;
	localparam logic [ADDR_W-1:0] ADR_REACH_THR   = 8'h03;
	localparam logic [ADDR_W-1:0] ADR_ZERO_THR    = 8'h04;
	localparam logic [ADDR_W-1:0] ADR_ACC_THR     = 8'h05;
	localparam logic [ADDR_W-1:0] ADR_FB_FILT     = 8'h06;
	localparam logic [ADDR_W-1:0] ADR_DISP_FILT   = 8'h07;
	localparam logic [ADDR_W-1:0] ADR_FILT_SPEED  = 8'h08;
	localparam logic [ADDR_W-1:0] ADR_DISP_SPEED  = 8'h09;
	localparam logic [ADDR_W-1:0] ADR_SPEED_OUT   = 8'h0A;
	localparam logic [ADDR_W-1:0] ADR_STATUS      = 8'h0B;
	localparam logic [ADDR_W-1:0] ADR_CTRL        = 8'h0C;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [SPD_W-1:0] RST_ZLOCK_THR = 16'h0005;
	localparam logic [SPD_W-1:0] RST_JOG_SPEED = 16'h0014;
	localparam logic [SPD_W-1:0] RST_CONS_THR  = 16'h000A;
	localparam logic [SPD_W-1:0] RST_REACH_THR = 16'h03E8;
	localparam logic [SPD_W-1:0] RST_ZERO_THR  = 16'h000A;
	localparam logic [SPD_W-1:0] RST_ACC_THR   = 16'h000A;
	localparam logic [3:0]       RST_FB_FILT   = 4'h2;
	localparam logic [3:0]       RST_DISP_FILT = 4'h8;
	localparam logic [SPD_W-1:0] RST_ZERO_SPD  = 16'h0000;

	// ****************************************************************
	// Control and status field positions
	// ****************************************************************
	localparam int CTRL_SPEED_MODE = 0;
	localparam int FILT_SHIFT_W    = 4;
	localparam int ST_CONSISTENT   = 0;
	localparam int ST_REACHED      = 1;
	localparam int ST_ZERO         = 2;
	localparam int ST_ACCEL        = 3;
	localparam int ST_DECEL        = 4;
	localparam int ST_FWD          = 5;
	localparam int ST_REV          = 6;
	localparam int ST_LOCKED       = 7;

	// Digital function inputs
	typedef struct packed {
		logic zero_lock_enable_in;
		logic fwd_jog_in;
		logic rev_jog_in;
		logic cmd_invert_in;
		logic speed_pause_in;
	} scs_din_t;

	// Speed status flags
	typedef struct packed {
		logic speed_consistent_out;
		logic speed_reached_out;
		logic zero_speed_out;
		logic accelerating_out;
		logic decelerating_out;
		logic fwd_rotation_out;
		logic rev_rotation_out;
	} scs_status_t;

	typedef enum logic {
		ST_FOLLOW,
		ST_ZLOCK
	} scs_lock_t;

	// Magnitude of a signed speed, saturating the most negative value
	function automatic logic [SPD_W-1:0] scs_abs(input logic signed [SPD_W-1:0] v);
		if (v == {1'b1, {(SPD_W-1){1'b0}}})
			scs_abs = {1'b0, {(SPD_W-1){1'b1}}};
		else if (v < 0)
			scs_abs = SPD_W'(-v);
		else
			scs_abs = v;
	endfunction : scs_abs

endpackage : scs_pkg

/* scs_lpf.sv */
// First-order low-pass filter with shift-programmable time constant
`timescale 1ns/1ns
module scs_lpf
	import scs_pkg::*;
#(
	parameter int W = 16
)
(
	input  wire logic                    clk_in,
	input  wire logic                    nrst_in,
	input  wire logic signed [W-1:0]     x_in,
	input  wire logic [FILT_SHIFT_W-1:0] shift_in,
	output logic signed [W-1:0]          y_out
);
	// ****************************************************************
	// Accumulator
	// ****************************************************************
	// Extra fraction bits keep small steps from being lost at long constants
	localparam int FW = 16;
	logic signed [W+FW-1:0] acc_q;
	logic signed [W+FW-1:0] err;

	always_comb
	begin
		err = (W+FW)'(signed'({x_in, {FW{1'b0}}}) - acc_q);
	end

	// acc += (x - acc) >> shift
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			acc_q <= '0;
		else
			acc_q <= acc_q + (err >>> shift_in);
	end

	assign y_out = acc_q[W+FW-1:FW];

endmodule : scs_lpf

/* scs_motor_model.sv */
// Motor and encoder model on the far side of the speed command block
`timescale 1ns/1ns
module scs_motor_model
	import scs_pkg::*;
(
	input  wire logic                    clk_in,
	input  wire logic                    nrst_in,
	input  wire logic signed [SPD_W-1:0] speed_in,
	input  wire logic                    slow_in,
	input  wire logic signed [SPD_W-1:0] load_in,
	input  wire logic signed [SPD_W-1:0] kick_in,
	output logic signed [SPD_W-1:0]      speed_fb_out,
	output logic signed [POS_W-1:0]      pos_fb_out
);
	int spd;

	// Rotor speed: prompt follows at once, slow closes 1/8 a cycle
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			spd <= 0;
		else if (slow_in)
			spd <= spd + ((int'(speed_in) - spd) >>> 3);
		else
			spd <= int'(speed_in);
	end

	// A positive load drags the measured speed below the command, a negative one lifts it above
	assign speed_fb_out = SPD_W'(spd - int'(load_in));

	// Encoder: one pulse a cycle while turning, kick is an outside push
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			pos_fb_out <= '0;
		else
			pos_fb_out <= pos_fb_out + POS_W'(kick_in)
				+ ((speed_in > 0) ? 1 : (speed_in < 0) ? -1 : 0);
	end
endmodule : scs_motor_model

/* speed_mode_command_and_status_tb.sv */
// Self-checking bench for the speed command and status block
`timescale 1ns/1ns
module speed_mode_command_and_status_tb;
	import scs_pkg::*;
	logic                    clk;
	logic                    nrst;
	logic [ADDR_W-1:0]       addr;
	logic [DATA_W-1:0]       wdata;
	logic                    wr;
	logic                    rd;
	logic [DATA_W-1:0]       rdata;
	scs_din_t                din;
	logic signed [SPD_W-1:0] cmd;
	logic signed [SPD_W-1:0] fb;
	logic signed [POS_W-1:0] pos;
	logic signed [SPD_W-1:0] spd;
	logic                    lock;
	scs_status_t             st;
	logic                    slow;
	logic signed [SPD_W-1:0] load;
	logic signed [SPD_W-1:0] kick;
	int                      fails;
	int                      total_checks;
	int                      seed;
	int                      jog;
	localparam logic [15:0] RV [9] = '{RST_ZLOCK_THR, RST_JOG_SPEED,
		RST_CONS_THR, RST_REACH_THR, RST_ZERO_THR, RST_ACC_THR,
		16'(RST_FB_FILT), 16'(RST_DISP_FILT), 16'h0001};
	localparam int CM [11] = '{1001, 1000, 9, 10, 11, -11, -10, 500,
		500, 500, 0};
	localparam int LD [11] = '{0, 0, 0, 0, 0, 0, 0, 9, 10, -10, 0};
	localparam int TO [5] = '{800, 805, 0, -800, 0};

	scs_speed_cmd uut (
		.CLK_SYS_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.DIN_IN(din), .SPEED_CMD_IN(cmd), .SPEED_FB_IN(fb),
		.POS_FB_IN(pos), .SPEED_OUT(spd), .ZERO_LOCK_OUT(lock),
		.STATUS_OUT(st));

	scs_motor_model motor (
		.clk_in(clk), .nrst_in(nrst), .speed_in(spd), .slow_in(slow),
		.load_in(load), .kick_in(kick), .speed_fb_out(fb),
		.pos_fb_out(pos));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************************************
	// Checking and bus tasks
	// ****************************************************************
	task automatic chk_val(logic [15:0] got, logic [15:0] exp, string m);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_val

	task automatic chk_st(scs_status_t got, scs_status_t exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t status got %b exp %b", $time, got, exp);
		end
	endtask : chk_st

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic bus_wr(logic [7:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr

	// Read data stands only in the cycle after the strobe
	task automatic bus_rd(logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : bus_rd

	// Inputs held long enough for sync, command and feedback stages
	task automatic drive(int c, logic [4:0] d);
		@(posedge clk);
		cmd <= SPD_W'(c);
		din <= d;
		repeat (12) @(posedge clk);
		#1;
	endtask : drive

	// ****************************************************************
	// Reference model
	// ****************************************************************
	function automatic int exp_cmd(int c, logic [4:0] d, bit m);
		int v;
		v = d[1] ? -c : c;
		if (m && d[3])
			v += jog;
		if (m && d[2])
			v -= jog;
		if (v > 32767)
			v = 32767;
		if (v < -32767)
			v = -32767;
		return d[0] ? 0 : v;
	endfunction : exp_cmd

	// Thresholds as ints, so negative speeds compare signed
	function automatic scs_status_t exp_st(int f, int c);
		scs_status_t e;
		int cth;
		int rth;
		int zth;
		cth = int'(RST_CONS_THR);
		rth = int'(RST_REACH_THR);
		zth = int'(RST_ZERO_THR);
		e = '0;
		e.speed_consistent_out = (f - c < cth) && (c - f < cth);
		e.speed_reached_out = (f > rth) || (-f > rth);
		e.zero_speed_out = (f < zth) && (-f < zth);
		e.fwd_rotation_out = f > zth;
		e.rev_rotation_out = -f > zth;
		return e;
	endfunction : exp_st

	// Watchdog against a hung run
	initial
	begin
		repeat (100000) @(posedge clk);
		fails++;
		$display("MISMATCH t=%0t run did not finish", $time);
		wrap_up();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		logic [15:0] r;
		int i;
		int k;
		int c;
		int n_acc;
		int n_dec;
		logic signed [POS_W-1:0] p0;
		{nrst, wr, rd, slow} = '0;
		{addr, wdata, din, cmd, load, kick} = '0;
		{fails, total_checks, jog} = '0;
		seed = 32'h00311161;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		// Reset values, unmapped hole and a jog write
		for (i = 0; i < 9; i++)
		begin
			bus_rd(i < 8 ? 8'(i) : ADR_CTRL, r);
			chk_val(r, RV[i], "reset value");
		end
		bus_rd(8'h3F, r);
		chk_val(r, 16'h0000, "unmapped read");
		jog = 1 + ($unsigned($random(seed)) % 2000);
		bus_wr(ADR_JOG_SPEED, 16'(jog));
		bus_rd(ADR_JOG_SPEED, r);
		chk_val(r, 16'(jog), "jog readback");
		bus_wr(ADR_FB_FILT, 16'h0000);
		// Every jog, invert and pause mix, random and saturating command
		for (k = 0; k < 2; k++)
			for (i = 0; i < 16; i++)
			begin
				c = k ? 32760 : $random(seed) % 30000;
				drive(c, 5'(i));
				chk_val(spd, 16'(exp_cmd(c, 5'(i), 1'b1)), "cmd");
				chk_val(16'(lock), 16'h0000, "lock off");
			end
		// Outside speed mode neither lock nor jog applies
		bus_wr(ADR_CTRL, 16'h0000);
		drive(3, 5'b11000);
		chk_val(16'(lock), 16'h0000, "lock no mode");
		chk_val(spd, 16'(exp_cmd(3, 5'b11000, 1'b0)), "jog no mode");
		bus_wr(ADR_CTRL, 16'h0001);
		// Lock at the threshold, push the shaft, then leave
		drive(5, 5'b10000);
		repeat (10) @(posedge clk);
		#1;
		chk_val(16'(lock), 16'h0001, "lock entry");
		chk_val(spd, 16'h0000, "lock ignores cmd");
		p0 = pos;
		@(posedge clk);
		kick <= 16'h0028;
		@(posedge clk);
		kick <= 16'h0000;
		repeat (4) @(posedge clk);
		#1;
		chk_val(16'(spd < 0), 16'h0001, "push resisted");
		repeat (80) @(posedge clk);
		#1;
		chk_val(16'(pos - p0 <= 2 && p0 - pos <= 2), 16'h0001, "pos");
		chk_val(spd, 16'h0000, "lock settled");
		bus_rd(ADR_SPEED_OUT, r);
		chk_val(r, 16'h0000, "lock out reg");
		drive(6, 5'b10000);
		chk_val(16'(lock), 16'h0000, "lock exit");
		chk_val(spd, 16'h0006, "resume cmd");
		drive(-5, 5'b10000);
		chk_val(16'(lock), 16'h0001, "lock negative");
		drive(-5, 5'b00000);
		chk_val(16'(lock), 16'h0000, "enable off");
		chk_val(spd, 16'hFFFB, "follow after lock");
		// Software raises the lock threshold
		bus_wr(ADR_ZLOCK_THR, 16'h0008);
		drive(-8, 5'b10000);
		chk_val(16'(lock), 16'h0001, "lock new thr");
		drive(-9, 5'b10000);
		chk_val(16'(lock), 16'h0000, "exit new thr");
		chk_val(spd, 16'hFFF7, "resume new thr");
		// Steady speeds around the reaching, zero-speed and consistency thresholds
		for (i = 0; i < 11; i++)
		begin
			load <= SPD_W'(LD[i]);
			drive(CM[i], 5'b00000);
			chk_st(st, exp_st(CM[i] - LD[i], CM[i]));
			bus_rd(ADR_FILT_SPEED, r);
			chk_val(r, 16'(CM[i] - LD[i]), "filtered");
			bus_rd(ADR_STATUS, r);
			chk_val(r, 16'(exp_st(CM[i] - LD[i], CM[i])), "st reg");
		end
		// Speed steps up, down and tiny, one with a slow rotor
		c = 0;
		for (i = 0; i < 5; i++)
		begin
			@(posedge clk);
			slow <= (i == 3);
			cmd <= SPD_W'(TO[i]);
			n_acc = 0;
			n_dec = 0;
			repeat (40)
			begin
				@(posedge clk);
				#1;
				n_acc += st.accelerating_out;
				n_dec += st.decelerating_out;
			end
			k = (TO[i] > c ? TO[i] - c : c - TO[i]) > RST_ACC_THR;
			chk_val(16'(n_acc > 0), 16'(k && TO[i] * TO[i] > c * c), "acc");
			chk_val(16'(n_dec > 0), 16'(k && TO[i] * TO[i] < c * c), "dec");
			c = TO[i];
		end
		// Feedback filter lags, display filter slower still
		bus_wr(ADR_FB_FILT, 16'h0002);
		drive(0, 5'b00000);
		@(posedge clk);
		cmd <= 16'h0320;
		repeat (3) @(posedge clk);
		bus_rd(ADR_FILT_SPEED, r);
		chk_val(16'($signed(r) > 0 && $signed(r) < 800), 16'h0001, "lag");
		repeat (100) @(posedge clk);
		bus_rd(ADR_FILT_SPEED, r);
		chk_val(16'(r >= 797 && r <= 800), 16'h0001, "settled");
		bus_rd(ADR_DISP_SPEED, r);
		chk_val(16'($signed(r) < 700), 16'h0001, "display lag");
		wrap_up();
	end
endmodule : speed_mode_command_and_status_tb
